// file: rtl/eepf_front_end.sv
// Two-wire client front end: conditions, byte framing, acknowledge and address decode.
`timescale 1ns/10ps
module eepf_front_end
   import eepf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              scl,
   input  wire logic              sda_i,
   output wire logic              sda_o,
   output wire logic              sda_oe_n,
   input  wire logic              client_select_high,
   input  wire logic              client_select_low,
   input  wire logic [7:0]        rd_byte,
   input  wire logic              write_cycle_done,
   output wire logic              standby,
   output wire logic              dev_read,
   output wire logic [ADDR_W-1:0] word_addr,
   output wire logic              rd_req,
   output wire logic [7:0]        wr_byte,
   output wire logic              wr_stb,
   output wire logic              write_cycle_start
);

   // Link domain: data is latched on every rising clock edge of the bus.
   logic              rise_bit_q;
   logic              rise_tog_q;

   always_ff @(posedge scl or negedge resetn) begin
      if (!resetn) begin
         rise_bit_q <= 1'b0;
         rise_tog_q <= 1'b0;
      end else begin
         rise_bit_q <= sda_i;
         rise_tog_q <= ~rise_tog_q;
      end
   end

   // The bit crosses beside the toggle; the toggle is read one stage later so that
   // the bit has settled even if the two first flops resolved on different edges.
   logic              tog_s1_q;
   logic              tog_s2_q;
   logic              tog_s3_q;
   logic              tog_s4_q;
   logic              bit_s1_q;
   logic              bit_s2_q;
   logic              rise_ev;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
         tog_s4_q <= 1'b0;
         bit_s1_q <= 1'b0;
         bit_s2_q <= 1'b0;
      end else begin
         tog_s1_q <= rise_tog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
         tog_s4_q <= tog_s3_q;
         bit_s1_q <= rise_bit_q;
         bit_s2_q <= bit_s1_q;
      end
   end

   assign rise_ev = tog_s3_q ^ tog_s4_q;

   // Line synchronisers, spike filter and condition detection.
   logic                scl_s1_q;
   logic                scl_s2_q;
   logic                sda_s1_q;
   logic                sda_s2_q;
   logic [FILT_LEN-1:0] scl_h_q;
   logic [FILT_LEN-1:0] sda_h_q;
   logic                scl_f_q;
   logic                sda_f_q;
   logic                scl_fp_q;
   logic                sda_fp_q;
   logic [1:0]          sel_s1_q;
   logic [1:0]          sel_s2_q;
   logic                start_det;
   logic                stop_det;
   logic                fall_ev;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scl_s1_q    <= 1'b1;
         scl_s2_q    <= 1'b1;
         sda_s1_q    <= 1'b1;
         sda_s2_q    <= 1'b1;
         scl_h_q     <= '1;
         sda_h_q     <= '1;
         scl_f_q     <= 1'b1;
         sda_f_q     <= 1'b1;
         scl_fp_q    <= 1'b1;
         sda_fp_q    <= 1'b1;
         sel_s1_q    <= 2'h0;
         sel_s2_q    <= 2'h0;
      end else begin
         scl_s1_q    <= scl;
         scl_s2_q    <= scl_s1_q;
         sda_s1_q    <= sda_i;
         sda_s2_q    <= sda_s1_q;
         scl_h_q     <= {scl_h_q[FILT_LEN-2:0], scl_s2_q};
         sda_h_q     <= {sda_h_q[FILT_LEN-2:0], sda_s2_q};
         if (&scl_h_q) begin
            scl_f_q <= 1'b1;
         end else if (~|scl_h_q) begin
            scl_f_q <= 1'b0;
         end
         if (&sda_h_q) begin
            sda_f_q <= 1'b1;
         end else if (~|sda_h_q) begin
            sda_f_q <= 1'b0;
         end
         scl_fp_q    <= scl_f_q;
         sda_fp_q    <= sda_f_q;
         sel_s1_q    <= {client_select_high, client_select_low};
         sel_s2_q    <= sel_s1_q;
      end
   end

   assign start_det = scl_f_q & scl_fp_q & sda_fp_q & ~sda_f_q;
   assign stop_det  = scl_f_q & scl_fp_q & ~sda_fp_q & sda_f_q;
   assign fall_ev   = scl_fp_q & ~scl_f_q;

   // Protocol engine.
   eepf_state_t       state_q;
   logic [3:0]        bit_cnt_q;
   logic [7:0]        shift_q;
   logic [7:0]        tx_q;
   logic              sda_oe_n_q;
   logic              sda_o_q;
   logic              rd_q;
   logic              host_nack_q;
   logic              wr_seen_q;
   logic              standby_q;
   logic [ADDR_W-1:0] word_addr_q;
   logic [7:0]        wr_byte_q;
   logic              wr_stb_q;
   logic              rd_req_q;
   logic              wc_start_q;
   logic              addr_match;

   assign addr_match = (shift_q[7:DA_TYPE_LSB] == DEV_TYPE_CODE)
                       && (shift_q[DA_SEL_HI] == sel_s2_q[1])
                       && (shift_q[DA_SEL_LO] == sel_s2_q[0]);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q     <= ST_STANDBY;
         bit_cnt_q   <= 4'h0;
         shift_q     <= 8'h00;
         tx_q        <= 8'hff;
         sda_oe_n_q  <= 1'b1;
         sda_o_q     <= 1'b0;
         rd_q        <= 1'b0;
         host_nack_q <= 1'b0;
         wr_seen_q   <= 1'b0;
         standby_q   <= 1'b1;
         word_addr_q <= '0;
         wr_byte_q   <= 8'h00;
         wr_stb_q    <= 1'b0;
         rd_req_q    <= 1'b0;
         wc_start_q  <= 1'b0;
      end else begin
         wr_stb_q   <= 1'b0;
         rd_req_q   <= 1'b0;
         wc_start_q <= 1'b0;
         if (state_q == ST_WR_BUSY) begin
            // Deaf to the bus until the array reports the write finished.
            sda_oe_n_q <= 1'b1;
            if (write_cycle_done) begin
               state_q   <= ST_STANDBY;
               standby_q <= 1'b1;
            end
         end else if (start_det) begin
            state_q     <= ST_DEV_ADDR;
            standby_q   <= 1'b0;
            bit_cnt_q   <= 4'h0;
            sda_oe_n_q  <= 1'b1;
            wr_seen_q   <= 1'b0;
            host_nack_q <= 1'b0;
         end else if (stop_det) begin
            sda_oe_n_q <= 1'b1;
            bit_cnt_q  <= 4'h0;
            if (wr_seen_q) begin
               state_q    <= ST_WR_BUSY;
               wc_start_q <= 1'b1;
            end else begin
               state_q   <= ST_STANDBY;
               standby_q <= 1'b1;
            end
         end else if (state_q != ST_STANDBY && state_q != ST_IGNORE) begin
            if (rise_ev && bit_cnt_q != CNT_ACK_DONE) begin
               if (bit_cnt_q != CNT_BYTE_DONE) begin
                  shift_q <= {shift_q[6:0], bit_s2_q};
               end else if (state_q == ST_RD_DATA) begin
                  host_nack_q <= bit_s2_q;
               end
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (fall_ev && bit_cnt_q == CNT_BYTE_DONE) begin
               sda_oe_n_q <= 1'b0;
               case (state_q)
                  ST_DEV_ADDR: begin
                     if (addr_match) begin
                        rd_q <= shift_q[DA_RW_BIT];
                        if (!shift_q[DA_RW_BIT]) begin
                           word_addr_q[ADDR_W-1] <= shift_q[DA_TOP_BIT];
                        end
                     end else begin
                        state_q    <= ST_IGNORE;
                        sda_oe_n_q <= 1'b1;
                     end
                  end
                  ST_WORD_ADDR: begin
                     word_addr_q[7:0] <= shift_q;
                  end
                  ST_WR_DATA: begin
                     wr_byte_q <= shift_q;
                     wr_stb_q  <= 1'b1;
                     wr_seen_q <= 1'b1;
                  end
                  default: begin
                     sda_oe_n_q <= 1'b1;
                  end
               endcase
            end else if (fall_ev && bit_cnt_q == CNT_ACK_DONE) begin
               bit_cnt_q  <= 4'h0;
               sda_oe_n_q <= 1'b1;
               case (state_q)
                  ST_DEV_ADDR: begin
                     if (rd_q) begin
                        state_q    <= ST_RD_DATA;
                        word_addr_q <= word_addr_q + 1'b1;
                        sda_oe_n_q <= rd_byte[7];
                        tx_q       <= {rd_byte[6:0], 1'b1};
                        rd_req_q   <= 1'b1;
                     end else begin
                        state_q <= ST_WORD_ADDR;
                     end
                  end
                  ST_WORD_ADDR: begin
                     state_q <= ST_WR_DATA;
                  end
                  ST_WR_DATA: begin
                     // Writes roll over inside the current page.
                     word_addr_q[PAGE_W-1:0] <= word_addr_q[PAGE_W-1:0] + 1'b1;
                  end
                  ST_RD_DATA: begin
                     if (host_nack_q) begin
                        state_q <= ST_IGNORE;
                     end else begin
                        word_addr_q <= word_addr_q + 1'b1;
                        sda_oe_n_q  <= rd_byte[7];
                        tx_q        <= {rd_byte[6:0], 1'b1};
                        rd_req_q    <= 1'b1;
                     end
                  end
                  default: begin
                     state_q <= ST_IGNORE;
                  end
               endcase
            end else if (fall_ev && state_q == ST_RD_DATA && bit_cnt_q < CNT_BYTE_DONE) begin
               sda_oe_n_q <= tx_q[7];
               tx_q       <= {tx_q[6:0], 1'b1};
            end
         end
      end
   end

   // The address steps past each read byte as it is latched, so rd_byte must follow word_addr.
   assign sda_o             = sda_o_q;
   assign sda_oe_n          = sda_oe_n_q;
   assign standby           = standby_q;
   assign dev_read          = rd_q;
   assign word_addr         = word_addr_q;
   assign rd_req            = rd_req_q;
   assign wr_byte           = wr_byte_q;
   assign wr_stb            = wr_stb_q;
   assign write_cycle_start = wc_start_q;

   a_sda_scl_low: assert property (@(posedge clk) disable iff (!resetn)
      $changed(sda_oe_n_q) && !$past(start_det) && !$past(stop_det) |-> !$past(scl_f_q))
      else $error("data line changed while clock high");
   a_start_wakes: assert property (@(posedge clk) disable iff (!resetn)
      start_det && state_q != ST_WR_BUSY |=> state_q == ST_DEV_ADDR && !standby_q && bit_cnt_q == 4'h0)
      else $error("start did not open a command");
   a_idle_silent: assert property (@(posedge clk) disable iff (!resetn)
      state_q == ST_STANDBY || state_q == ST_IGNORE |-> sda_oe_n_q)
      else $error("data line driven while idle or ignoring");
   a_stop_standby: assert property (@(posedge clk) disable iff (!resetn)
      stop_det && state_q != ST_WR_BUSY && !wr_seen_q |=> standby_q && state_q == ST_STANDBY)
      else $error("stop did not return to standby");
   a_ack_match: assert property (@(posedge clk) disable iff (!resetn)
      fall_ev && bit_cnt_q == CNT_BYTE_DONE && state_q == ST_DEV_ADDR && !start_det && !stop_det
      |=> sda_oe_n_q == !$past(addr_match))
      else $error("address acknowledge does not follow the match");
   a_ack_release: assert property (@(posedge clk) disable iff (!resetn)
      fall_ev && bit_cnt_q == CNT_ACK_DONE && (state_q == ST_WORD_ADDR || state_q == ST_WR_DATA)
      && !start_det && !stop_det |=> sda_oe_n_q && bit_cnt_q == 4'h0)
      else $error("ack not released after ninth clock");
   a_nack_release: assert property (@(posedge clk) disable iff (!resetn)
      fall_ev && bit_cnt_q == CNT_ACK_DONE && state_q == ST_RD_DATA && host_nack_q
      && !start_det && !stop_det |=> sda_oe_n_q && state_q == ST_IGNORE)
      else $error("read not ended after host nack");
   a_busy_deaf: assert property (@(posedge clk) disable iff (!resetn)
      state_q == ST_WR_BUSY && !write_cycle_done |=> state_q == ST_WR_BUSY && sda_oe_n_q)
      else $error("bus answered during write cycle");
   a_write_stop: assert property (@(posedge clk) disable iff (!resetn)
      stop_det && wr_seen_q && state_q != ST_WR_BUSY |=> wc_start_q && state_q == ST_WR_BUSY ##1 !wc_start_q)
      else $error("write stop did not start one write cycle");

endmodule // eepf_front_end

// file: rtl/eepf_pkg.sv
// Constants and types shared by the serial EEPROM client front end.
package eepf_pkg;

   // Array organisation: fixed-size pages, page count selects the density.
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_COUNT = 32;
   localparam int ADDR_W     = $clog2(PAGE_BYTES * PAGE_COUNT);
   localparam int PAGE_W     = $clog2(PAGE_BYTES);

   // Device-type code in the address byte; the value is arbitrary.
   localparam logic [3:0] DEV_TYPE_CODE = 4'h5;

   // Field positions inside the device address byte.
   localparam int DA_TYPE_LSB = 4;
   localparam int DA_SEL_HI   = 3;
   localparam int DA_SEL_LO   = 2;
   localparam int DA_TOP_BIT  = 1;
   localparam int DA_RW_BIT   = 0;

   // Clock counts within one nine-clock byte frame.
   localparam logic [3:0] CNT_BYTE_DONE = 4'h8;
   localparam logic [3:0] CNT_ACK_DONE  = 4'h9;

   // Samples that must agree before a filtered line level changes.
   localparam int FILT_LEN = 3;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_DEV_ADDR,
      ST_WORD_ADDR,
      ST_WR_DATA,
      ST_RD_DATA,
      ST_IGNORE,
      ST_WR_BUSY
   } eepf_state_t;

endpackage

// file: sim/eepf_host_model.sv
// Behavioural two-wire bus host that drives the serial clock and pulls the data line.
`timescale 1ns/10ps
module eepf_host_model (
   input  wire logic lclk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe_n
);
   // Nine link-clock cycles per clock phase keep each phase above the client's filter lag.
   localparam int HALF = 9;

   initial begin
      scl      = 1'b1;
      sda_oe_n = 1'b1;
   end

   task automatic wait_l(input int n);
      repeat (n) @(posedge lclk);
   endtask

   // Data moves only mid-way through the low phase and is sampled mid-way through the high phase.
   task automatic bit_cycle(input logic b, output logic s);
      wait_l(4);
      sda_oe_n <= b;
      wait_l(HALF - 4);
      scl <= 1'b1;
      wait_l(4);
      s = sda;
      wait_l(HALF - 4);
      scl <= 1'b0;
   endtask

   // Works from idle and as a repeated start after a ninth clock.
   task automatic start();
      wait_l(4);
      sda_oe_n <= 1'b1;
      wait_l(HALF - 4);
      scl <= 1'b1;
      wait_l(HALF);
      sda_oe_n <= 1'b0;
      wait_l(HALF);
      scl <= 1'b0;
   endtask

   task automatic stop();
      wait_l(4);
      sda_oe_n <= 1'b0;
      wait_l(HALF - 4);
      scl <= 1'b1;
      wait_l(HALF);
      sda_oe_n <= 1'b1;
      wait_l(HALF);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
      bit_cycle(1'b1, ack);
   endtask

   task automatic recv_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
      bit_cycle(nack, s);
   endtask
endmodule // eepf_host_model

// file: sim/tb.sv
// Self-checking bench for the serial EEPROM client front end.
`timescale 1ns/10ps
module tb;
   import eepf_pkg::*;
   logic              clk, resetn, lclk, sel_hi, sel_lo, write_cycle_done, s, ack;
   logic [31:0]       rng;
   logic [8:0]        exp_addr;
   logic [7:0]        wr_q[$];
   logic [7:0]        flip[4] = '{8'h80, 8'h10, 8'h08, 8'h04};
   int                bad_count, total_checks, cyc, wcs_seen;
   wire logic         scl, sda, sda_o, sda_oe_n, host_oe_n, standby, dev_read, rd_req, wr_stb, write_cycle_start;
   wire logic [7:0]   rd_byte, wr_byte;
   wire logic [ADDR_W-1:0] word_addr;

   // Open-drain data line with pull-up: low if either party pulls.
   assign sda = host_oe_n & (sda_oe_n | sda_o);

   function automatic logic [7:0] mem_val(input logic [8:0] a);
      return a[7:0] ^ 8'h3c ^ {7'h00, a[8]};
   endfunction
   // The array answers at once, so the byte is settled whenever a read latches it.
   assign rd_byte = mem_val(word_addr);

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic logic [7:0] dev_addr(input logic top, input logic rw);
      return {DEV_TYPE_CODE, sel_hi, sel_lo, top, rw};
   endfunction

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #7;
      forever #24 lclk = ~lclk;
   end

   eepf_host_model host_u (.lclk(lclk), .sda(sda), .scl(scl), .sda_oe_n(host_oe_n));

   eepf_front_end dut_u (
      .clk(clk), .resetn(resetn), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .client_select_high(sel_hi), .client_select_low(sel_lo), .rd_byte(rd_byte),
      .write_cycle_done(write_cycle_done), .standby(standby), .dev_read(dev_read), .word_addr(word_addr),
      .rd_req(rd_req), .wr_byte(wr_byte), .wr_stb(wr_stb), .write_cycle_start(write_cycle_start)
   );

   always @(posedge clk) begin
      if (wr_stb === 1'b1) wr_q.push_back(wr_byte);
      if (write_cycle_start === 1'b1) wcs_seen++;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      total_checks++;
      if (seen !== expv) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic finish_test();
      if (bad_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic pick_sel();
      logic [31:0] r;
      r = xs();
      @(posedge clk);
      sel_hi <= r[0];
      sel_lo <= r[1];
      repeat (4) @(posedge clk);
   endtask

   task automatic write_txn(input logic [8:0] a, input int n);
      logic [7:0] d;
      logic [8:0] e;
      e = a;
      host_u.start();
      host_u.send_byte(dev_addr(a[8], 1'b0), ack);
      check(ack, 1'b0);
      check(dev_read, 1'b0);
      host_u.send_byte(a[7:0], ack);
      check(ack, 1'b0);
      for (int i = 0; i < n; i++) begin
         d = xs();
         host_u.send_byte(d, ack);
         check(ack, 1'b0);
         check(wr_q.pop_front(), d);
         e[3:0] = e[3:0] + 4'h1;
      end
      // The address steps a few cycles after the ninth falling clock edge.
      repeat (12) @(posedge clk);
      check(word_addr, e);
      exp_addr = e;
      wcs_seen = 0;
      host_u.stop();
      check(wcs_seen, (n > 0));
      check(standby, (n == 0));
      if (n > 0) begin
         host_u.start();
         host_u.send_byte(dev_addr(a[8], 1'b0), ack);
         check(ack, 1'b1);
         host_u.stop();
         @(posedge clk);
         write_cycle_done <= 1'b1;
         @(posedge clk);
         write_cycle_done <= 1'b0;
         repeat (4) @(posedge clk);
         check(standby, 1'b1);
      end
   endtask

   task automatic read_txn(input logic [8:0] a, input logic cur, input int n);
      logic [7:0] d;
      logic [8:0] e;
      e = cur ? exp_addr : a;
      host_u.start();
      if (!cur) begin
         host_u.send_byte(dev_addr(a[8], 1'b0), ack);
         check(ack, 1'b0);
         host_u.send_byte(a[7:0], ack);
         check(ack, 1'b0);
         host_u.start();
      end
      host_u.send_byte(dev_addr(cur ? ~e[8] : a[8], 1'b1), ack);
      check(ack, 1'b0);
      check(dev_read, 1'b1);
      for (int i = 0; i < n; i++) begin
         host_u.recv_byte(i == n - 1, d);
         check(d, mem_val(e));
         e = e + 9'h001;
      end
      repeat (20) @(posedge clk);
      check(sda_oe_n, 1'b1);
      host_u.stop();
      check(standby, 1'b1);
   endtask

   initial begin
      rng = 32'd17979;
      resetn = 1'b0;
      sel_hi = 1'b0;
      sel_lo = 1'b0;
      write_cycle_done = 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (12) @(posedge clk);
      check(standby, 1'b1);
      check(sda_oe_n, 1'b1);
      write_txn(9'h1fe, 3);
      read_txn(9'h000, 1'b1, 1);
      write_txn(9'h020, 0);
      foreach (flip[k]) begin
         pick_sel();
         host_u.start();
         host_u.send_byte(dev_addr(1'b0, 1'b0) ^ flip[k], ack);
         check(ack, 1'b1);
         host_u.send_byte(8'h00, ack);
         check(ack, 1'b1);
         host_u.stop();
      end
      for (int k = 0; k < 4; k++) begin
         pick_sel();
         write_txn(9'(xs()), 1 + int'(xs() % 4));
         read_txn(9'(xs()), 1'b0, 2);
      end
      host_u.start();
      host_u.send_byte(dev_addr(1'b0, 1'b1), ack);
      repeat (3) host_u.bit_cycle(1'b1, s);
      repeat (9) host_u.bit_cycle(1'b1, s);
      check(s, 1'b1);
      write_txn(9'h0f0, 0);
      finish_test();
   end
endmodule // tb
